// ---- timer16_pins.sv ----
/*
 * far-side model: trigger, event and byte-timer pins of the unit.
 * assumes one stimulus thread calls drive() at a time.
 */
`default_nettype none
module timer16_pins (
  input wire logic clk_i,      // system clock
  output logic [4:0] pins_o    // {byte flop, b1, a1, b0, a0}
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_o = 5'h00;
  // ***************************************************************
  // pin driver
  // ***************************************************************
  // a level lasts hold+1 cycles; even hold 0 is sampled once by the unit, so no edge is lost
  task automatic drive(input logic [4:0] v, input int hold);
    @(posedge clk_i);
    pins_o <= v;
    repeat (hold) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- timer16_pkg.sv ----
/*
 * constants, field layouts and carrier types for the dual 16-bit
 * timer/capture unit. assumes a 32-bit classic wishbone slave port
 * with byte-lane selects and one register per aligned word.
 */
`default_nettype none
package timer16_pkg;
  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFS_RUN = 8'h00;
  localparam logic [7:0] OFS_BUFFER = 8'h04;
  localparam logic [7:0] OFS_MODE [2] = '{8'h08, 8'h0c};
  localparam logic [7:0] OFS_FLOP [2] = '{8'h10, 8'h14};
  localparam logic [7:0] OFS_MATCH_FIRST [2] = '{8'h18, 8'h20};
  localparam logic [7:0] OFS_MATCH_SECOND [2] = '{8'h1c, 8'h24};
  localparam logic [7:0] OFS_LATCH_FIRST [2] = '{8'h28, 8'h30};
  localparam logic [7:0] OFS_LATCH_SECOND [2] = '{8'h2c, 8'h34};
  localparam logic [7:0] OFS_STATUS = 8'h38;
  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int unsigned RUN_CH_BIT [2] = '{0, 1};
  localparam int unsigned RUN_PRE_BIT = 7;
  localparam int unsigned SHADOW_BIT [2] = '{0, 1};
  localparam logic [7:0] RUN_RESET = 8'h00;
  localparam logic [1:0] BUFFER_RESET = 2'h0;
  localparam logic [7:0] MODE_RESET = 8'h20;
  localparam logic [3:0] FLOP_TRIG_RESET = 4'h0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // ***************************************************************
  // prescaler taps: a tap fires when its low counter bits are all ones
  // ***************************************************************
  localparam int unsigned PRE_W = 6;
  localparam logic [5:0] TAP1_MASK = 6'h03;
  localparam logic [5:0] TAP4_MASK = 6'h0f;
  localparam logic [5:0] TAP16_MASK = 6'h3f;
  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    CLK_EXT, CLK_TAP1, CLK_TAP4, CLK_TAP16
  } clk_sel_t;
  typedef enum logic [1:0] {
    LATCH_OFF, LATCH_TWO_PINS, LATCH_PULSE, LATCH_BYTE_TIMER
  } latch_mode_t;
  typedef enum logic [1:0] {
    FLOP_INVERT, FLOP_CLEAR, FLOP_SET, FLOP_HOLD
  } flop_cmd_t;
  typedef struct packed {
    logic b_on_match;
    logic b_on_latch;
    logic soft_latch;
    latch_mode_t latch_mode;
    logic clear_en;
    clk_sel_t clk_sel;
  } mode_ctrl_t;
  typedef struct packed {
    flop_cmd_t b_cmd;
    logic [3:0] a_trig;
    flop_cmd_t a_cmd;
  } flop_ctrl_t;
  typedef struct packed {
    logic ovf;
    logic match_first;
    logic match_second;
    logic pin_fall;
  } chan_irq_t;
endpackage
`default_nettype wire

// ---- timer16_unit.sv ----
/*
 * dual 16-bit timer/event counter with compare, capture and output
 * flops, behind a classic wishbone slave. assumes trigger pins are
 * asynchronous and the byte-timer flop input is on clk_i.
 */
// Function
// - counter clock is tap or external pin
// - overflow raises channel overflow interrupt
// - reset clears run control, all stopped
// - two compare registers, equality gives match
// - compare registers write-only, undefined after reset
// - shadow only on first compare, per-channel enable
// - second-compare match moves shadow into first
// - reset clears buffer control, shadow off
// - write hits shadow only while buffering enabled; code writes shadow on every write, compare only while buffering off
// - capture registers read-only, byte or halfword reads
// - latch mode 00 disables capture
// - mode 01 rising edges of two pins
// - mode 10 rise/fall, falling-edge pin interrupt
// - mode 11 byte-timer flop rise/fall edges
// - writing soft latch 0 captures immediately
// - each compare match raises own interrupt
// - second match clears counter unless disabled
// - flop a toggles on four enabled triggers
// - flop b toggles on mode bits 6,7
// - flop commands clear, set or invert
// - external clock counts pin rising edges
`default_nettype none
module timer16_unit (
  input wire logic clk_i,                  // system clock, 200 MHz
  input wire logic rst_i,                  // synchronous reset
  input wire logic wb_cyc_i,               // bus cycle
  input wire logic wb_stb_i,               // strobe
  input wire logic wb_we_i,                // write enable
  input wire logic [7:0] wb_adr_i,         // byte address
  input wire logic [31:0] wb_dat_i,        // write data
  input wire logic [3:0] wb_sel_i,         // byte lanes
  output logic [31:0] wb_dat_o,            // read data
  output logic wb_ack_o,                   // acknowledge
  input wire logic trig_in_a_ch0_i,        // ch0 clock/trigger pin a
  input wire logic trig_in_b_ch0_i,        // ch0 trigger pin b
  input wire logic trig_in_a_ch1_i,        // ch1 clock/trigger pin a
  input wire logic trig_in_b_ch1_i,        // ch1 trigger pin b
  input wire logic byte_timer_flop_i,      // 8-bit timer output flop
  output logic out_pin_a_ch0_o,            // ch0 flop a
  output logic out_pin_b_ch0_o,            // ch0 flop b
  output logic out_pin_a_ch1_o,            // ch1 flop a
  output logic out_pin_b_ch1_o,            // ch1 flop b
  output logic overflow_irq_ch0_o,         // ch0 overflow pulse
  output logic overflow_irq_ch1_o,         // ch1 overflow pulse
  output logic match_first_irq_ch0_o,      // ch0 first match pulse
  output logic match_second_irq_ch0_o,     // ch0 second match pulse
  output logic match_first_irq_ch1_o,      // ch1 first match pulse
  output logic match_second_irq_ch1_o,     // ch1 second match pulse
  output logic pin_irq_falling_ch0_o,      // ch0 pin a falling pulse
  output logic pin_irq_falling_ch1_o       // ch1 pin a falling pulse
);
  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [3:0] pins;
  logic [3:0] s1_reg, s2_reg, s3_reg;
  logic [3:0] s1_next, s2_next, s3_next;
  logic btf_prev_reg, btf_prev_next;
  logic [3:0] pin_rise, pin_fall;

  assign pins = {trig_in_b_ch1_i, trig_in_a_ch1_i,
                 trig_in_b_ch0_i, trig_in_a_ch0_i};

  always_comb begin
    s1_next = pins;
    s2_next = s1_reg;
    s3_next = s2_reg;
    btf_prev_next = byte_timer_flop_i;
    // an edge shows while stage two holds the new level and stage three still holds the old one
    pin_rise = s2_reg & ~s3_reg;
    pin_fall = ~s2_reg & s3_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
      btf_prev_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      btf_prev_reg <= btf_prev_next;
    end
  end

  // ***************************************************************
  // timer state
  // ***************************************************************
  logic [7:0] run_reg, run_next;
  logic [1:0] shadow_en_reg, shadow_en_next;
  logic [timer16_pkg::PRE_W-1:0] pre_reg, pre_next;
  timer16_pkg::mode_ctrl_t mode_reg [2];
  timer16_pkg::mode_ctrl_t mode_next [2];
  logic [3:0] trig_reg [2];
  logic [3:0] trig_next [2];
  logic [15:0] cnt_reg [2];
  logic [15:0] cnt_next [2];
  logic [15:0] cmp_a_reg [2];
  logic [15:0] cmp_a_next [2];
  logic [15:0] shadow_reg [2];
  logic [15:0] shadow_next [2];
  logic [15:0] cmp_b_reg [2];
  logic [15:0] cmp_b_next [2];
  logic [15:0] cap_a_reg [2];
  logic [15:0] cap_a_next [2];
  logic [15:0] cap_b_reg [2];
  logic [15:0] cap_b_next [2];
  logic [1:0] flop_a_reg, flop_a_next, flop_b_reg, flop_b_next;
  timer16_pkg::chan_irq_t irq_reg [2];
  timer16_pkg::chan_irq_t irq_next [2];
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [1:0] tick, run, m1_ev, m2_ev, ovf_ev, latch_first_ch0_ev, latch_second_ch0_ev;
  logic [1:0] soft_ev, cmp_a_wr, flop_wr;
  logic acc, wr;
  timer16_pkg::flop_ctrl_t fw;

  localparam logic [5:0] TAP_MASK [4] = '{6'h00, timer16_pkg::TAP1_MASK,
    timer16_pkg::TAP4_MASK, timer16_pkg::TAP16_MASK};

  always_comb begin
    acc = wb_cyc_i & wb_stb_i;
    // writes land at the edge where ack is seen high
    wr = acc & wb_we_i & ack_reg;
    ack_next = acc & ~ack_reg;
    dat_next = dat_reg;
    fw = timer16_pkg::flop_ctrl_t'(wb_dat_i[7:0]);
    run_next = run_reg;
    shadow_en_next = shadow_en_reg;
    flop_a_next = flop_a_reg;
    flop_b_next = flop_b_reg;
    if (wr && wb_adr_i == timer16_pkg::OFS_RUN) begin
      run_next = merge8(run_reg, wb_dat_i, wb_sel_i);
    end
    if (wr && wb_adr_i == timer16_pkg::OFS_BUFFER && wb_sel_i[0]) begin
      shadow_en_next = wb_dat_i[1:0];
    end
    // the prescaler wraps on its own width; a stopped prescaler restarts at 0
    pre_next = run_reg[timer16_pkg::RUN_PRE_BIT] ?
               pre_reg + 6'h01 : '0;
    for (int c = 0; c < 2; c++) begin
      mode_next[c] = mode_reg[c];
      trig_next[c] = trig_reg[c];
      cmp_a_next[c] = cmp_a_reg[c];
      shadow_next[c] = shadow_reg[c];
      cmp_b_next[c] = cmp_b_reg[c];
      cap_a_next[c] = cap_a_reg[c];
      cap_b_next[c] = cap_b_reg[c];
      run[c] = run_reg[timer16_pkg::RUN_CH_BIT[c]];
      // clock select; taps only run with the prescaler
      if (mode_reg[c].clk_sel == timer16_pkg::CLK_EXT) begin
        tick[c] = pin_rise[2*c];
      end else begin
        tick[c] = run_reg[timer16_pkg::RUN_PRE_BIT] &&
          ((pre_reg & TAP_MASK[mode_reg[c].clk_sel]) ==
           TAP_MASK[mode_reg[c].clk_sel]);
      end
      m1_ev[c] = run[c] & tick[c] & (cnt_reg[c] == cmp_a_reg[c]);
      m2_ev[c] = run[c] & tick[c] & (cnt_reg[c] == cmp_b_reg[c]);
      ovf_ev[c] = run[c] & tick[c] &
                  (cnt_reg[c] == timer16_pkg::COUNT_MAX) &
                  ~(m2_ev[c] & mode_reg[c].clear_en);
      if (!run[c]) begin
        cnt_next[c] = '0;
      end else if (m2_ev[c] && mode_reg[c].clear_en) begin
        cnt_next[c] = '0;
      end else if (tick[c]) begin
        cnt_next[c] = 16'(cnt_reg[c] + 16'h0001);
      end else begin
        cnt_next[c] = cnt_reg[c];
      end
      // ---- capture sources
      soft_ev[c] = wr && wb_adr_i == timer16_pkg::OFS_MODE[c] &&
                   wb_sel_i[0] && !wb_dat_i[5];
      case (mode_reg[c].latch_mode)
        timer16_pkg::LATCH_TWO_PINS: begin
          latch_first_ch0_ev[c] = pin_rise[2*c];
          latch_second_ch0_ev[c] = pin_rise[2*c+1];
        end
        timer16_pkg::LATCH_PULSE: begin
          latch_first_ch0_ev[c] = pin_rise[2*c];
          latch_second_ch0_ev[c] = pin_fall[2*c];
        end
        timer16_pkg::LATCH_BYTE_TIMER: begin
          latch_first_ch0_ev[c] = byte_timer_flop_i & ~btf_prev_reg;
          latch_second_ch0_ev[c] = ~byte_timer_flop_i & btf_prev_reg;
        end
        default: begin
          latch_first_ch0_ev[c] = 1'b0;
          latch_second_ch0_ev[c] = 1'b0;
        end
      endcase
      latch_first_ch0_ev[c] = latch_first_ch0_ev[c] | soft_ev[c];
      if (latch_first_ch0_ev[c]) begin
        cap_a_next[c] = cnt_reg[c];
      end
      if (latch_second_ch0_ev[c]) begin
        cap_b_next[c] = cnt_reg[c];
      end
      // ---- mode and flop control writes
      if (wr && wb_adr_i == timer16_pkg::OFS_MODE[c] && wb_sel_i[0]) begin
        mode_next[c] = timer16_pkg::mode_ctrl_t'(wb_dat_i[7:0]);
        mode_next[c].soft_latch = 1'b1;
      end
      flop_wr[c] = wr && wb_adr_i == timer16_pkg::OFS_FLOP[c] &&
                   wb_sel_i[0];
      if (flop_wr[c]) begin
        trig_next[c] = fw.a_trig;
      end
      // ---- compare writes; the shadow sits at the first's address
      cmp_a_wr[c] = wr && wb_adr_i == timer16_pkg::OFS_MATCH_FIRST[c];
      if (cmp_a_wr[c]) begin
        shadow_next[c] = merge16(shadow_reg[c], wb_dat_i, wb_sel_i);
        if (!shadow_en_reg[c]) begin
          cmp_a_next[c] = merge16(cmp_a_reg[c], wb_dat_i, wb_sel_i);
        end
      end
      if (shadow_en_reg[c] && m2_ev[c]) begin
        cmp_a_next[c] = shadow_reg[c];
      end
      if (wr && wb_adr_i == timer16_pkg::OFS_MATCH_SECOND[c]) begin
        cmp_b_next[c] = merge16(cmp_b_reg[c], wb_dat_i, wb_sel_i);
      end
      // ---- output flops; a software command beats a trigger
      if (flop_wr[c] && fw.a_cmd != timer16_pkg::FLOP_HOLD) begin
        case (fw.a_cmd)
          timer16_pkg::FLOP_CLEAR: flop_a_next[c] = 1'b0;
          timer16_pkg::FLOP_SET: flop_a_next[c] = 1'b1;
          default: flop_a_next[c] = ~flop_a_reg[c];
        endcase
      end else if (|(trig_reg[c] &
                    {latch_second_ch0_ev[c], latch_first_ch0_ev[c], m2_ev[c], m1_ev[c]})) begin
        flop_a_next[c] = ~flop_a_reg[c];
      end
      if (flop_wr[c] && fw.b_cmd != timer16_pkg::FLOP_HOLD) begin
        case (fw.b_cmd)
          timer16_pkg::FLOP_CLEAR: flop_b_next[c] = 1'b0;
          timer16_pkg::FLOP_SET: flop_b_next[c] = 1'b1;
          default: flop_b_next[c] = ~flop_b_reg[c];
        endcase
      end else if ((mode_reg[c].b_on_latch && latch_second_ch0_ev[c]) ||
                   (mode_reg[c].b_on_match && m2_ev[c])) begin
        flop_b_next[c] = ~flop_b_reg[c];
      end
      irq_next[c].ovf = ovf_ev[c];
      irq_next[c].match_first = m1_ev[c];
      irq_next[c].match_second = m2_ev[c];
      irq_next[c].pin_fall = pin_fall[2*c] &&
        mode_reg[c].latch_mode == timer16_pkg::LATCH_PULSE;
    end
    // ---- read mux; compare addresses read as zero
    if (acc && !ack_reg) begin
      dat_next = 32'h0000_0000;
      if (wb_adr_i == timer16_pkg::OFS_RUN) begin
        dat_next[7:0] = run_reg;
      end else if (wb_adr_i == timer16_pkg::OFS_BUFFER) begin
        dat_next[1:0] = shadow_en_reg;
      end else if (wb_adr_i == timer16_pkg::OFS_STATUS) begin
        dat_next[3:0] = {flop_b_reg[1], flop_a_reg[1],
                         flop_b_reg[0], flop_a_reg[0]};
      end
      for (int c = 0; c < 2; c++) begin
        if (wb_adr_i == timer16_pkg::OFS_MODE[c]) begin
          dat_next[7:0] = mode_reg[c];
        end
        if (wb_adr_i == timer16_pkg::OFS_FLOP[c]) begin
          dat_next[7:0] = {2'h3, trig_reg[c], 2'h3};
        end
        if (wb_adr_i == timer16_pkg::OFS_LATCH_FIRST[c]) begin
          dat_next[15:0] = cap_a_reg[c];
        end
        if (wb_adr_i == timer16_pkg::OFS_LATCH_SECOND[c]) begin
          dat_next[15:0] = cap_b_reg[c];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= timer16_pkg::RUN_RESET;
      shadow_en_reg <= timer16_pkg::BUFFER_RESET;
      pre_reg <= '0;
      flop_a_reg <= 2'h0;
      flop_b_reg <= 2'h0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      for (int c = 0; c < 2; c++) begin
        mode_reg[c] <= timer16_pkg::MODE_RESET;
        trig_reg[c] <= timer16_pkg::FLOP_TRIG_RESET;
        cnt_reg[c] <= 16'h0000;
        cmp_a_reg[c] <= 16'h0000;
        shadow_reg[c] <= 16'h0000;
        cmp_b_reg[c] <= 16'h0000;
        cap_a_reg[c] <= 16'h0000;
        cap_b_reg[c] <= 16'h0000;
        irq_reg[c] <= '0;
      end
    end else begin
      run_reg <= run_next;
      shadow_en_reg <= shadow_en_next;
      pre_reg <= pre_next;
      flop_a_reg <= flop_a_next;
      flop_b_reg <= flop_b_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      for (int c = 0; c < 2; c++) begin
        mode_reg[c] <= mode_next[c];
        trig_reg[c] <= trig_next[c];
        cnt_reg[c] <= cnt_next[c];
        cmp_a_reg[c] <= cmp_a_next[c];
        shadow_reg[c] <= shadow_next[c];
        cmp_b_reg[c] <= cmp_b_next[c];
        cap_a_reg[c] <= cap_a_next[c];
        cap_b_reg[c] <= cap_b_next[c];
        irq_reg[c] <= irq_next[c];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign out_pin_a_ch0_o = flop_a_reg[0];
  assign out_pin_b_ch0_o = flop_b_reg[0];
  assign out_pin_a_ch1_o = flop_a_reg[1];
  assign out_pin_b_ch1_o = flop_b_reg[1];
  assign overflow_irq_ch0_o = irq_reg[0].ovf;
  assign overflow_irq_ch1_o = irq_reg[1].ovf;
  assign match_first_irq_ch0_o = irq_reg[0].match_first;
  assign match_second_irq_ch0_o = irq_reg[0].match_second;
  assign match_first_irq_ch1_o = irq_reg[1].match_first;
  assign match_second_irq_ch1_o = irq_reg[1].match_second;
  assign pin_irq_falling_ch0_o = irq_reg[0].pin_fall;
  assign pin_irq_falling_ch1_o = irq_reg[1].pin_fall;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  stop_clears_a: assert property (
    !run_reg[0] |=> cnt_reg[0] == 16'h0000)
    else $error("stopped counter not cleared");
  overflow_wrap_a: assert property (
    overflow_irq_ch0_o |-> $past(cnt_reg[0]) == 16'hffff &&
                           cnt_reg[0] == 16'h0000)
    else $error("overflow pulse without wrap");
  match_clear_a: assert property (
    match_second_irq_ch0_o && $past(mode_reg[0].clear_en)
    |-> cnt_reg[0] == 16'h0000)
    else $error("second match did not clear");
  no_clear_a: assert property (
    match_second_irq_ch0_o && !$past(mode_reg[0].clear_en)
    |-> cnt_reg[0] == 16'($past(cnt_reg[0]) + 16'h0001))
    else $error("counter cleared with clear disabled");
  first_match_a: assert property (
    match_first_irq_ch0_o |-> $past(cnt_reg[0]) == $past(cmp_a_reg[0]))
    else $error("first match pulse without equality");
  shadow_move_a: assert property (
    match_second_irq_ch0_o && $past(shadow_en_reg[0])
    |-> cmp_a_reg[0] == $past(shadow_reg[0]))
    else $error("shadow not transferred");
  buffered_write_a: assert property (
    cmp_a_wr[0] && shadow_en_reg[0] && !m2_ev[0]
    |=> $stable(cmp_a_reg[0]))
    else $error("buffered write reached compare");
  soft_latch_a: assert property (
    soft_ev[1] |=> cap_a_reg[1] == $past(cnt_reg[1]))
    else $error("soft latch missed counter");
  pin_irq_mode_a: assert property (
    pin_irq_falling_ch0_o |-> $past(mode_reg[0].latch_mode) ==
                              timer16_pkg::LATCH_PULSE)
    else $error("pin interrupt outside pulse mode");
  latch_off_a: assert property (
    mode_reg[0].latch_mode == timer16_pkg::LATCH_OFF
    |=> $stable(cap_b_reg[0]))
    else $error("capture while disabled");
  flop_clear_a: assert property (
    flop_wr[0] && fw.a_cmd == timer16_pkg::FLOP_CLEAR |=> !flop_a_reg[0])
    else $error("flop clear command ignored");
  ack_once_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  overflow_c: cover property (overflow_irq_ch0_o);
  shadow_c: cover property (match_second_irq_ch0_o && shadow_en_reg[0]);
  pulse_c: cover property (pin_irq_falling_ch1_o);
  flop_c: cover property ($rose(out_pin_a_ch0_o));
endmodule
`default_nettype wire

// ---- timer16_unit_tb_top.sv ----
/*
 * self-checking bench for the dual 16-bit timer/capture unit.
 * assumes the single-cycle wishbone answer and tick rates of the unit.
 */
`default_nettype none
module timer16_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o;
  logic [4:0] pins;
  logic [3:0] outp;
  logic [1:0] ovf, mf, ms, pf;
  int errors = 0, n_tests = 0, nfall = 0;
  always #2.5 clk_i = ~clk_i;
  timer16_pins timer16_pins_inst (.clk_i(clk_i), .pins_o(pins));
  timer16_unit timer16_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .trig_in_a_ch0_i(pins[0]),
    .trig_in_b_ch0_i(pins[1]), .trig_in_a_ch1_i(pins[2]),
    .trig_in_b_ch1_i(pins[3]), .byte_timer_flop_i(pins[4]),
    .out_pin_a_ch0_o(outp[0]), .out_pin_b_ch0_o(outp[1]),
    .out_pin_a_ch1_o(outp[2]), .out_pin_b_ch1_o(outp[3]),
    .overflow_irq_ch0_o(ovf[0]), .overflow_irq_ch1_o(ovf[1]),
    .match_first_irq_ch0_o(mf[0]), .match_second_irq_ch0_o(ms[0]),
    .match_first_irq_ch1_o(mf[1]), .match_second_irq_ch1_o(ms[1]),
    .pin_irq_falling_ch0_o(pf[0]), .pin_irq_falling_ch1_o(pf[1]));
  always @(posedge clk_i) if (pf[0] === 1'b1) nfall++;
  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64) check("bus ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask
  task automatic rdc(input string name, input logic [7:0] a,
                     input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(name, exp, rd);
  endtask
  // cycles from a second-compare pulse to the next first-compare pulse
  task automatic gap(input int exp);
    int n;
    logic b;
    n = 0;
    b = outp[1];
    do @(posedge clk_i); while (ms[0] !== 1'b1 && n++ < 200);
    check("flop b toggle", {31'h0, ~b}, {31'h0, outp[1]});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (mf[0] !== 1'b1 && n < 200);
    check("match gap", exp, n);
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset;
    rdc("run_ctrl", timer16_pkg::OFS_RUN, 32'h0);
    rdc("buffer_ctrl", timer16_pkg::OFS_BUFFER, 32'h0);
    rdc("mode_ctrl", timer16_pkg::OFS_MODE[0], 32'h20);
    rdc("compare", timer16_pkg::OFS_MATCH_FIRST[0], 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    $display("test reset done");
  endtask
  // tap16 ticks every 64 cycles, so 128 cycles between edges is 2 counts
  task automatic t_capture;
    logic [15:0] a;
    for (int m = 0; m < 4; m++) begin
      wr(timer16_pkg::OFS_MODE[0], {24'h0, 3'b001, 2'(m), 3'b011});
      nfall = 0;
      timer16_pins_inst.drive((m == 3) ? 5'h10 : 5'h01, 127);
      timer16_pins_inst.drive((m == 1) ? 5'h03 : 5'h00, 7);
      timer16_pins_inst.drive(5'h00, 7);
      bus(1'b0, timer16_pkg::OFS_LATCH_FIRST[0], 32'h0, 4'h1);
      a[7:0] = rd[7:0];
      bus(1'b0, timer16_pkg::OFS_LATCH_FIRST[0], 32'h0, 4'h2);
      a[15:8] = rd[15:8];
      bus(1'b0, timer16_pkg::OFS_LATCH_SECOND[0], 32'h0, 4'h3);
      check("latch diff", m ? 2 : 0, 16'(rd - a));
      check("falling irq", 32'(m == 2), 32'(nfall));
    end
    $display("test capture done");
  endtask
  task automatic t_extcount;
    wr(timer16_pkg::OFS_MODE[1], 32'h20);
    repeat (5) begin
      timer16_pins_inst.drive(5'h04, 3);
      timer16_pins_inst.drive(5'h00, 3);
    end
    wr(timer16_pkg::OFS_MODE[1], 32'h00);
    rdc("pin count", timer16_pkg::OFS_LATCH_FIRST[1], 32'h5);
    $display("test external count done");
  endtask
  task automatic t_flops;
    logic [7:0] cmd [3] = '{8'h81, 8'h42, 8'h00};
    logic [1:0] st [3] = '{2'h2, 2'h1, 2'h2};
    for (int i = 0; i < 3; i++) begin
      wr(timer16_pkg::OFS_FLOP[0], {24'h0, cmd[i]});
      rdc("flop status", timer16_pkg::OFS_STATUS, {30'h0, st[i]});
      check("flop pins", {30'h0, st[i]}, {28'h0, outp});
    end
    wr(timer16_pkg::OFS_FLOP[0], 32'hd3);
    wr(timer16_pkg::OFS_MODE[0], 32'h03);
    rdc("flop toggle", timer16_pkg::OFS_STATUS, 32'h3);
    $display("test flops done");
  endtask
  task automatic t_shadow;
    wr(timer16_pkg::OFS_RUN, 32'h82);
    wr(timer16_pkg::OFS_BUFFER, 32'h0);
    wr(timer16_pkg::OFS_MATCH_FIRST[0], 32'h2);
    bus(1'b1, timer16_pkg::OFS_MATCH_SECOND[0], 32'h7, 4'h1);
    bus(1'b1, timer16_pkg::OFS_MATCH_SECOND[0], 32'h0, 4'h2);
    wr(timer16_pkg::OFS_MODE[0], 32'ha5);
    wr(timer16_pkg::OFS_RUN, 32'h83);
    gap(12);
    wr(timer16_pkg::OFS_BUFFER, 32'h1);
    wr(timer16_pkg::OFS_MATCH_FIRST[0], 32'h5);
    gap(24);
    $display("test shadow done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    wr(timer16_pkg::OFS_RUN, 32'h83);
    t_capture;
    t_extcount;
    t_flops;
    t_shadow;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
